// File: verilog/gcd_pkg.sv
// Package of constants and types for the global configuration and dual address block
// Overview of operation
// - After releasing expansion bus, stay off for release gap plus 4 clock periods.
// - Clock enable 0 floats expansion clock; 1 drives inverted host clock.
// - Style 0: bus request/grant, address strobe, read/write and read strobe.
// - Style 1: hold request/acknowledge, address latch, write and data strobes.
// - Address held address hold plus one periods, then address strobe asserted.
// - Data held data hold plus one periods, then data strobes asserted.
// - Mapping 0: port n feeds channel group n alone.
// - Mapping 1: port k feeds groups 2k and 2k+1.
// - Mapping 2: port 0 feeds groups 0-3, port 1 groups 4-7; 3 reserved.
// - Upper base zero gives single address cycles; non-zero gives dual cycles.
// - Single cycle: address and command driven for one clock.
// - Dual cycle: extra clock, dual command first, access type second.
// - 64-bit address: upper half from upper base, lower from normal address.
// - As target, claim only 32-bit single address cycles, never dual ones.
// - Activity flags read-only, clear after read, on group or chip reset.
// - Activity flag sets on second line clock rising edge while flag is 0.
package gcd_pkg;
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFS_GCFG        = 4'h0;
  localparam logic [3:0]  OFS_UBASE       = 4'h4;
  localparam logic [3:0]  OFS_ISTAT       = 4'h8;
  localparam logic [3:0]  OFS_IMASK       = 4'hC;
  localparam int          POS_GAP         = 12;
  localparam int          POS_EXPANSION_CLOCK_ENABLE       = 11;
  localparam int          POS_STYLE       = 10;
  localparam int          POS_AHOLD       = 8;
  localparam int          POS_DHOLD       = 4;
  localparam int          POS_MAP         = 0;
  localparam logic [31:0] GCFG_WMASK      = 32'h00007F73;
  localparam logic [31:0] GCFG_RST        = 32'h00000000;
  localparam logic [31:0] UBASE_RST       = 32'h00000000;
  localparam logic [3:0]  GAP_BASE        = 4'h4;
  localparam logic [3:0]  CMD_DUAL        = 4'hD;
  localparam int          CLK_MHZ         = 200;
  localparam int          NGRP            = 8;
  typedef enum logic [2:0] {EB_IDLE, EB_REQ, EB_ADDR, EB_DATA, EB_GAP} gcd_eb_t;
  typedef enum logic [1:0] {PM_IDLE, PM_HI, PM_LO} gcd_pm_t;
endpackage : gcd_pkg

// File: verilog/gcd_top.sv
// Global configuration, expansion bus sequencer and dual address master front end
`timescale 1ns/100ps
module gcd_top #(
  parameter int NGROUPS = gcd_pkg::NGRP
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic [gcd_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  output logic                             irq,
  input  wire logic                        soft_chip_reset,
  input  wire logic [7:0]                  soft_group_reset,
  input  wire logic [7:0]                  tx_line_clk,
  input  wire logic [7:0]                  rx_line_clk,
  output logic [7:0][2:0]                  group_port_sel,
  input  wire logic                        host_clk_in,
  output logic                             expansion_clock_out,
  output logic                             expansion_clock_out_oe,
  input  wire logic                        eb_start,
  input  wire logic                        eb_write,
  input  wire logic [31:0]                 eb_addr,
  input  wire logic [31:0]                 eb_wdata,
  output logic                             eb_busy,
  output logic                             eb_done,
  output logic                             style_a_bus_request_n,
  input  wire logic                        style_a_bus_grant_n,
  output logic                             style_a_address_strobe_n,
  output logic                             style_a_rw,
  output logic                             style_a_read_strobe_n,
  output logic                             style_b_hold_request,
  input  wire logic                        style_b_hold_acknowledge,
  output logic                             style_b_addr_latch_n,
  output logic                             style_b_write_strobe_n,
  output logic                             data_strobe_line_n,
  output logic      [31:0]                 eb_ad_out,
  output logic                             eb_ad_oe,
  input  wire logic                        pm_start,
  input  wire logic [31:0]                 pm_addr,
  input  wire logic [3:0]                  pm_cmd,
  output logic      [31:0]                 pci_ad_out,
  output logic      [3:0]                  pci_cbe_out,
  output logic                             pci_addr_phase,
  output logic                             pm_addr_done,
  output logic      [63:0]                 pm_full_addr,
  input  wire logic                        tgt_addr_phase,
  input  wire logic [3:0]                  tgt_cbe,
  output logic                             tgt_claim_ok
);
  import gcd_pkg::*;

  logic [31:0] gcfg_ff;
  logic [31:0] ubase_ff;
  logic [31:0] istat_ff;
  logic [31:0] imask_ff;
  logic [15:0] act_ff;
  logic [15:0] edge1_ff;
  logic [15:0] s1_ff, s2_ff, s3_ff;
  logic        hc1_ff, hc2_ff, hc3_ff;
  logic        ack1_ff, ack2_ff, ack3_ff;
  logic        expansion_clock_out_ff;
  logic        ecen;
  logic [15:0] clr_act;
  logic [31:0] gcfg_rd;
  logic        eb_grant;
  gcd_eb_t     eb_ff;
  logic [3:0]  cnt_ff;
  gcd_pm_t     pm_ff;
  logic [3:0]  pm_cmd_ff;
  logic [31:0] pm_addr_ff;
  logic [3:0]  ev;

  function automatic logic [2:0] map_port(input logic [1:0] m, input logic [2:0] g);
    case (m)
      2'h1:    map_port = {1'b0, g[2:1]};
      2'h2:    map_port = {2'b00, g[2]};
      default: map_port = g;
    endcase
  endfunction : map_port

  // Three-stage sync on external clocks; only stages 2 and 3 are compared
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff   <= 16'h0000;
      s2_ff   <= 16'h0000;
      s3_ff   <= 16'h0000;
      hc1_ff  <= 1'b0;
      hc2_ff  <= 1'b0;
      hc3_ff  <= 1'b0;
      ack1_ff <= 1'b0;
      ack2_ff <= 1'b0;
      ack3_ff <= 1'b0;
    end else begin
      s1_ff   <= {tx_line_clk, rx_line_clk};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      hc1_ff  <= host_clk_in;
      hc2_ff  <= hc1_ff;
      hc3_ff  <= hc2_ff;
      ack1_ff <= gcfg_ff[POS_STYLE] ? style_b_hold_acknowledge : ~style_a_bus_grant_n;
      ack2_ff <= ack1_ff;
      ack3_ff <= ack2_ff;
    end
  end

  assign clr_act = {soft_group_reset, soft_group_reset} | {16{soft_chip_reset}};
  assign ecen    = hc2_ff & ~hc3_ff;
  assign eb_grant = ack2_ff & ack3_ff;

  // Activity flags: second rising edge while flag is clear; read or reset clears
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_ff   <= 16'h0000;
      edge1_ff <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (!act_ff[i] && s2_ff[i] && !s3_ff[i] && edge1_ff[i] && !clr_act[i]) begin
          act_ff[i] <= 1'b1;  // Set beats a same-cycle read clear
        end else if (clr_act[i] || (reg_rd && reg_addr == OFS_GCFG)) begin
          act_ff[i]   <= 1'b0;
          edge1_ff[i] <= 1'b0;
        end else if (!act_ff[i] && s2_ff[i] && !s3_ff[i]) begin
          edge1_ff[i] <= 1'b1;
        end
      end
    end
  end

  // Register writes; soft chip reset restores gcfg_ff and ubase_ff defaults but keeps imask_ff
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gcfg_ff  <= GCFG_RST;
      ubase_ff <= UBASE_RST;
      imask_ff <= 32'h00000000;
    end else if (soft_chip_reset) begin
      gcfg_ff  <= GCFG_RST;
      ubase_ff <= UBASE_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_GCFG) begin
        gcfg_ff <= reg_wdata & GCFG_WMASK;
      end else if (reg_addr == OFS_UBASE) begin
        ubase_ff <= reg_wdata;
      end else if (reg_addr == OFS_IMASK) begin
        imask_ff <= {28'h0000000, reg_wdata[3:0]};
      end
    end
  end

  // Events: 0 expansion done, 1 master address done, 2 dual cycle, 3 claim refused
  assign ev = {tgt_addr_phase & ~tgt_claim_ok, pm_ff == PM_HI,
               pm_addr_done, eb_done};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      istat_ff <= 32'h00000000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ev[i]) begin
          istat_ff[i] <= 1'b1;  // Set beats write-one clear
        end else if (reg_wr && reg_addr == OFS_ISTAT && reg_wdata[i]) begin
          istat_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(istat_ff & imask_ff);

  assign gcfg_rd = {act_ff[15:12], act_ff[7:4], act_ff[11:8], act_ff[3:0], gcfg_ff[15:0]};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == OFS_GCFG) begin
        reg_rdata <= gcfg_rd;
      end else if (reg_addr == OFS_UBASE) begin
        reg_rdata <= ubase_ff;
      end else if (reg_addr == OFS_ISTAT) begin
        reg_rdata <= istat_ff;
      end else if (reg_addr == OFS_IMASK) begin
        reg_rdata <= imask_ff;
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  always_comb begin
    for (int g = 0; g < 8; g++) begin
      group_port_sel[g] = map_port(gcfg_ff[POS_MAP +: 2], g[2:0]);
    end
  end

  // Inverted copy of host clock, floated when disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expansion_clock_out_ff <= 1'b1;  // Inverse of the cleared sync stage
    end else begin
      expansion_clock_out_ff <= ~hc2_ff;
    end
  end
  assign expansion_clock_out    = expansion_clock_out_ff;
  assign expansion_clock_out_oe = gcfg_ff[POS_EXPANSION_CLOCK_ENABLE];

  // Expansion bus sequencer, timed in expansion clock periods
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eb_ff     <= EB_IDLE;
      cnt_ff    <= 4'h0;
      eb_ad_out <= 32'h00000000;
    end else begin
      case (eb_ff)
        EB_IDLE: begin
          if (eb_start) begin
            eb_ff     <= EB_REQ;
            eb_ad_out <= eb_addr;
          end
        end
        EB_REQ: begin
          if (eb_grant && ecen) begin
            eb_ff  <= EB_ADDR;
            cnt_ff <= {2'b00, gcfg_ff[POS_AHOLD +: 2]};
          end
        end
        EB_ADDR: begin
          if (ecen) begin
            if (cnt_ff == 4'h0) begin
              eb_ff     <= EB_DATA;
              cnt_ff    <= {1'b0, gcfg_ff[POS_DHOLD +: 3]};
              eb_ad_out <= eb_write ? eb_wdata : 32'h00000000;
            end else begin
              cnt_ff <= cnt_ff - 4'h1;
            end
          end
        end
        EB_DATA: begin
          if (ecen) begin
            if (cnt_ff == 4'h0) begin
              eb_ff  <= EB_GAP;
              cnt_ff <= {1'b0, gcfg_ff[POS_GAP +: 3]} + GAP_BASE - 4'h1;
            end else begin
              cnt_ff <= cnt_ff - 4'h1;
            end
          end
        end
        EB_GAP: begin
          if (ecen) begin
            if (cnt_ff == 4'h0) begin
              eb_ff <= EB_IDLE;
            end else begin
              cnt_ff <= cnt_ff - 4'h1;
            end
          end
        end
        default: eb_ff <= EB_IDLE;
      endcase
    end
  end

  logic own, astb, dstb, sty;
  assign sty     = gcfg_ff[POS_STYLE];
  assign own     = eb_ff == EB_ADDR || eb_ff == EB_DATA;
  assign astb    = eb_ff == EB_ADDR && cnt_ff == 4'h0;
  assign dstb    = eb_ff == EB_DATA && cnt_ff == 4'h0;
  assign eb_busy = eb_ff != EB_IDLE;
  assign eb_done = eb_ff == EB_DATA && cnt_ff == 4'h0 && ecen;
  assign eb_ad_oe = own;
  assign style_a_bus_request_n    = ~(!sty && (eb_ff == EB_REQ || own));
  assign style_a_address_strobe_n = ~(!sty && astb);
  assign style_a_rw               = !sty && !eb_write;
  assign style_a_read_strobe_n    = ~(!sty && dstb && !eb_write);
  assign style_b_hold_request     = sty && (eb_ff == EB_REQ || own);
  assign style_b_addr_latch_n     = ~(sty && astb);
  assign style_b_write_strobe_n   = ~(sty && dstb && eb_write);
  assign data_strobe_line_n       = ~dstb;

  // PCI master address phase: one clock, or two with dual address command
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pm_ff        <= PM_IDLE;
      pm_cmd_ff    <= 4'h0;
      pm_addr_ff   <= 32'h00000000;
      pm_full_addr <= 64'h0;
    end else begin
      case (pm_ff)
        PM_IDLE: begin
          if (pm_start) begin
            pm_addr_ff   <= pm_addr;
            pm_full_addr <= {ubase_ff, pm_addr};
            if (ubase_ff != 32'h00000000) begin
              pm_ff     <= PM_HI;
              pm_cmd_ff <= CMD_DUAL;
            end else begin
              pm_ff     <= PM_LO;
              pm_cmd_ff <= pm_cmd;
            end
          end
        end
        PM_HI: begin
          pm_ff     <= PM_LO;
          pm_cmd_ff <= pm_cmd;
        end
        default: pm_ff <= PM_IDLE;
      endcase
    end
  end

  assign pci_addr_phase = pm_ff != PM_IDLE;
  assign pci_cbe_out    = pm_cmd_ff;
  assign pci_ad_out     = (pm_ff == PM_HI) ? pm_full_addr[63:32] : pm_addr_ff;
  assign pm_addr_done   = pm_ff == PM_LO;
  assign tgt_claim_ok   = tgt_addr_phase && tgt_cbe != CMD_DUAL;

  property p_single;
    @(posedge clk) disable iff (!arst_n)
      (pm_start && pm_ff == PM_IDLE && ubase_ff == 32'h0) |=> pm_ff == PM_LO ##1 pm_ff == PM_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single address phase not one clock");

  sequence s_dual;
    pm_ff == PM_HI && pci_cbe_out == CMD_DUAL ##1 pm_ff == PM_LO;
  endsequence
  property p_dual;
    @(posedge clk) disable iff (!arst_n)
      (pm_start && pm_ff == PM_IDLE && ubase_ff != 32'h0) |=> s_dual;
  endproperty
  a_dual: assert property (p_dual) else $error("dual address phase wrong");

  property p_upper;
    @(posedge clk) disable iff (!arst_n)
      (pm_start && pm_ff == PM_IDLE) |=> pm_full_addr[63:32] == $past(ubase_ff);
  endproperty
  a_upper: assert property (p_upper) else $error("upper address not from base");

  property p_tgt;
    @(posedge clk) disable iff (!arst_n) tgt_cbe == CMD_DUAL |-> !tgt_claim_ok;
  endproperty
  a_tgt: assert property (p_tgt) else $error("dual cycle claimed as target");

  property p_expansion_clock_out;
    @(posedge clk) disable iff (!arst_n)
      ##1 expansion_clock_out == ~$past(hc2_ff) && expansion_clock_out_oe == gcfg_ff[11];
  endproperty
  a_expansion_clock_out: assert property (p_expansion_clock_out) else $error("expansion clock wrong");

  property p_rsvd;
    @(posedge clk) disable iff (!arst_n) (gcfg_ff[15] == 1'b0) && (gcfg_ff[7] == 1'b0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_rdclr;
    @(posedge clk) disable iff (!arst_n)
      (reg_rd && reg_addr == OFS_GCFG) |=>
        (act_ff & ~$past(~act_ff & s2_ff & ~s3_ff & edge1_ff)) == 16'h0;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("activity flag not cleared on read");

  property p_gap;
    @(posedge clk) disable iff (!arst_n)
      (eb_ff == EB_DATA && dstb && ecen) |=>
        eb_ff == EB_GAP && cnt_ff == $past(gcfg_ff[14:12]) + 3;
  endproperty
  a_gap: assert property (p_gap) else $error("release gap not loaded");

  property p_map;
    @(posedge clk) disable iff (!arst_n)
      gcfg_ff[1:0] == 2'h1 |-> group_port_sel[7] == 3'h3 && group_port_sel[2] == 3'h1;
  endproperty
  a_map: assert property (p_map) else $error("port map wrong");
endmodule : gcd_top

// File: test/gcd_arb_model.sv
// Expansion bus arbiter model answering both handshake styles
`timescale 1ns/100ps
module gcd_arb_model #(
  parameter int DLY = 3
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic style_a_bus_request_n,
  input  wire logic style_b_hold_request,
  output logic      style_a_bus_grant_n,
  output logic      style_b_hold_acknowledge
);
  logic [7:0] wait_ff;
  logic       req;
  assign req = !style_a_bus_request_n || style_b_hold_request;
  // Grant lags request; drops one cycle after the request goes away
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 8'h00;
      style_a_bus_grant_n <= 1'b1;
      style_b_hold_acknowledge <= 1'b0;
    end else begin
      wait_ff <= req ? wait_ff + ((wait_ff < 8'hFF) ? 8'h01 : 8'h00) : 8'h00;
      style_a_bus_grant_n <= !(!style_a_bus_request_n && wait_ff >= DLY);
      style_b_hold_acknowledge <= style_b_hold_request && wait_ff >= DLY;
    end
  end
endmodule : gcd_arb_model

// File: test/tb.sv
// Self-checking bench for the global configuration block
`timescale 1ns/100ps
module tb;
  import gcd_pkg::*;
  logic clk, arst_n, reg_wr, reg_rd, irq, host_clk_in, soft_chip_reset;
  logic [3:0] reg_addr, pm_cmd, pci_cbe_out, tgt_cbe;
  logic [31:0] reg_wdata, reg_rdata, eb_addr, eb_wdata, eb_ad_out, pm_addr, pci_ad_out;
  logic [7:0] soft_group_reset, tx_line_clk, rx_line_clk;
  logic [7:0][2:0] group_port_sel;
  logic expansion_clock_out, expansion_clock_out_oe, eb_start, eb_write, eb_busy, eb_done;
  logic style_a_bus_request_n, style_a_bus_grant_n, style_a_address_strobe_n, style_a_rw;
  logic style_a_read_strobe_n, style_b_hold_request, style_b_hold_acknowledge;
  logic style_b_addr_latch_n, style_b_write_strobe_n, data_strobe_line_n, eb_ad_oe;
  logic pm_start, pci_addr_phase, pm_addr_done, tgt_addr_phase, tgt_claim_ok;
  logic [63:0] pm_full_addr;
  int err_count, cmp_count, cyc;
  gcd_top u_gcd_top (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .soft_chip_reset, .soft_group_reset, .tx_line_clk, .rx_line_clk, .group_port_sel,
    .host_clk_in, .expansion_clock_out, .expansion_clock_out_oe, .eb_start, .eb_write,
    .eb_addr, .eb_wdata, .eb_busy, .eb_done, .style_a_bus_request_n, .style_a_bus_grant_n,
    .style_a_address_strobe_n, .style_a_rw, .style_a_read_strobe_n, .style_b_hold_request,
    .style_b_hold_acknowledge, .style_b_addr_latch_n, .style_b_write_strobe_n,
    .data_strobe_line_n, .eb_ad_out, .eb_ad_oe, .pm_start, .pm_addr, .pm_cmd, .pci_ad_out,
    .pci_cbe_out, .pci_addr_phase, .pm_addr_done, .pm_full_addr, .tgt_addr_phase, .tgt_cbe,
    .tgt_claim_ok);
  gcd_arb_model u_gcd_arb_model (.clk, .arst_n, .style_a_bus_request_n,
    .style_b_hold_request, .style_a_bus_grant_n, .style_b_hold_acknowledge);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Host clock spans exactly 8 core cycles, phase unrelated to clk
  initial begin
    host_clk_in = 1'b0;
    #1.3;
    forever #20 host_clk_in = ~host_clk_in;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic t_regs;
    logic [31:0] v;
    rd(OFS_GCFG, v);
    chk(v, GCFG_RST);
    wr(OFS_GCFG, 32'hFFFF_FFFF);
    rd(OFS_GCFG, v);
    chk(v, 32'h0000_7F73);
    chk(expansion_clock_out_oe, 1'b1);
    @(posedge host_clk_in);
    repeat (6) @(posedge clk);
    chk(expansion_clock_out, 1'b0);
    @(negedge host_clk_in);
    repeat (6) @(posedge clk);
    chk(expansion_clock_out, 1'b1);
    wr(OFS_GCFG, 32'h0);
    @(posedge clk);
    chk(expansion_clock_out_oe, 1'b0);
    wr(OFS_UBASE, 32'hA5A5_0001);
    rd(OFS_UBASE, v);
    chk(v, 32'hA5A5_0001);
    wr(OFS_UBASE, 32'h0);
    rd(4'h2, v);
    chk(v, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_map;
    for (int m = 0; m < 3; m++) begin
      wr(OFS_GCFG, m);
      @(posedge clk);
      for (int g = 0; g < 8; g++) chk(group_port_sel[g], g >> m);
    end
    $display("t_map done");
  endtask : t_map
  task automatic t_pm(input logic [31:0] ub);
    wr(OFS_UBASE, ub);
    pm_start <= 1'b1;
    @(posedge clk);
    pm_start <= 1'b0;
    @(posedge clk);
    if (ub != 0) begin
      chk({pci_addr_phase, pm_addr_done, pci_cbe_out}, {2'b10, CMD_DUAL});
      chk(pci_ad_out, ub);
      @(posedge clk);
    end
    chk({pci_addr_phase, pm_addr_done, pci_cbe_out}, {2'b11, pm_cmd});
    chk(pci_ad_out, pm_addr);
    @(posedge clk);
    chk(pci_addr_phase, 1'b0);
    if (ub != 0) chk(pm_full_addr, {ub, pm_addr});
    $display("t_pm done");
  endtask : t_pm
  task automatic t_tgt;
    logic [31:0] v;
    wr(OFS_ISTAT, 32'hF);
    tgt_addr_phase <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      tgt_cbe <= 4'(c);
      @(posedge clk);
      @(posedge clk);
      chk(tgt_claim_ok, c != CMD_DUAL);
    end
    tgt_addr_phase <= 1'b0;
    rd(OFS_ISTAT, v);
    chk(v, 32'h8);
    $display("t_tgt done");
  endtask : t_tgt
  task automatic t_irq;
    logic [31:0] v;
    wr(OFS_ISTAT, 32'hF);
    wr(OFS_IMASK, 32'h2);
    t_pm(32'h0);
    chk(irq, 1'b1);
    rd(OFS_ISTAT, v);
    chk(v, 32'h2);
    wr(OFS_IMASK, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    wr(OFS_IMASK, 32'h2);
    wr(OFS_ISTAT, 32'h2);
    @(posedge clk);
    chk(irq, 1'b0);
    rd(OFS_ISTAT, v);
    chk(v, 32'h0);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_eb(input logic s, input logic [1:0] a, input logic [2:0] d,
                      input logic [2:0] g, input logic w);
    int na, nas, nds, nd, nb;
    logic bad, oka, okd;
    wr(OFS_GCFG, {17'h0, g, 1'b0, s, a, 1'b0, d, 4'h0});
    eb_write <= w;
    eb_addr <= 32'h0000_0AB0 + a;
    eb_wdata <= 32'h5A00_0000 + d;
    eb_start <= 1'b1;
    @(posedge clk);
    eb_start <= 1'b0;
    {na, nas, nds, nd, nb} = {5{-1}};
    bad = 1'b0;
    for (int n = 0; n < 3000 && nb < 0; n++) begin
      @(posedge clk);
      if (eb_ad_oe && na < 0) na = n;
      if ((s ? !style_b_addr_latch_n : !style_a_address_strobe_n) && nas < 0) begin
        nas = n;
        oka = eb_ad_out === eb_addr;
      end
      if (!(style_a_read_strobe_n && style_b_write_strobe_n && data_strobe_line_n)
          && nds < 0) begin
        nds = n;
        okd = (!w || eb_ad_out === eb_wdata) && style_a_rw === (!s && !w)
              && style_a_read_strobe_n === !(!s && !w) && style_b_write_strobe_n === !(s && w);
      end
      if (eb_done) nd = n;
      if (nd >= 0 && !eb_busy) nb = n;
      // Request and address strobe lines of the unselected style must stay idle
      bad |= s ? (!style_a_bus_request_n || !style_a_address_strobe_n)
               : (style_b_hold_request || !style_b_addr_latch_n);
    end
    chk(bad, 1'b0);
    chk((nas - na + 4) / 8, a);
    chk(oka, 1'b1);
    chk((nds - na + 4) / 8, a + 1 + d);
    chk(okd, 1'b1);
    chk((nb - nd + 4) / 8, g + 4);
    $display("t_eb done");
  endtask : t_eb
  task automatic rise(input logic tx, input int i);
    if (tx) tx_line_clk[i] <= 1'b1;
    else rx_line_clk[i] <= 1'b1;
    repeat (4) @(posedge clk);
    tx_line_clk <= 8'h00;
    rx_line_clk <= 8'h00;
    repeat (4) @(posedge clk);
  endtask : rise
  task automatic t_act;
    logic [31:0] v;
    rd(OFS_GCFG, v);
    rise(1'b1, 3);
    rise(1'b0, 5);
    rise(1'b0, 5);
    rd(OFS_GCFG, v);
    chk(v[31:16], 16'h0200);
    rd(OFS_GCFG, v);
    chk(v[31:16], 16'h0000);
    rise(1'b0, 5);
    rise(1'b0, 5);
    soft_group_reset <= 8'h20;
    @(posedge clk);
    soft_group_reset <= 8'h00;
    rd(OFS_GCFG, v);
    chk(v[31:16], 16'h0000);
    wr(OFS_GCFG, 32'h0000_0002);
    soft_chip_reset <= 1'b1;
    @(posedge clk);
    soft_chip_reset <= 1'b0;
    rd(OFS_GCFG, v);
    chk(v, 32'h0);
    $display("t_act done");
  endtask : t_act
  initial begin
    {arst_n, reg_wr, reg_rd, soft_chip_reset, eb_start, eb_write, pm_start} = '0;
    {tgt_addr_phase, reg_addr, tgt_cbe, soft_group_reset, tx_line_clk, rx_line_clk} = '0;
    {reg_wdata, eb_addr, eb_wdata} = '0;
    pm_addr = 32'h1234_5670;
    pm_cmd = 4'h6;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_map();
    t_pm(32'h0);
    t_pm(32'h8000_0003);
    t_pm(32'h0);
    t_tgt();
    t_irq();
    t_eb(1'b0, 2'h1, 3'h2, 3'h1, 1'b1);
    t_eb(1'b1, 2'h3, 3'h0, 3'h3, 1'b0);
    t_eb(1'b0, 2'h0, 3'h7, 3'h7, 1'b0);
    t_eb(1'b1, 2'h2, 3'h1, 3'h0, 1'b1);
    t_act();
    end_sim();
  end
endmodule : tb
